// ===== rtl/light_sensor_regs.vh
// register pointers, configuration fields, reset values and timing constants
`ifndef LIGHT_SENSOR_REGS_VH
`define LIGHT_SENSOR_REGS_VH

`define PTR_RESULT 8'h00
`define PTR_CONFIG 8'h01
`define PTR_UPPER 8'h02
`define PTR_LOWER 8'h03
`define PTR_MAKER 8'h7e

`define CFG_RANGE_HI 15
`define CFG_RANGE_LO 12
`define CFG_LONG 11
`define CFG_MODE_HI 10
`define CFG_MODE_LO 9
`define CFG_OVF 8
`define CFG_READY 7
`define CFG_HIGH 6
`define CFG_LOW 5
`define CFG_LATCH 4
`define CFG_POL 3
`define CFG_EXPMASK 2
`define CFG_WR_MASK 16'hfe1c

`define MODE_SHUTDOWN 2'h0
`define MODE_SINGLE 2'h1
`define MODE_CONT 2'h2

`define RANGE_MAX 4'hb
`define UPPER_RESET 16'hbfff
`define LOWER_RESET 16'h0000
`define CONFIG_RESET 16'h0000
`define SLAVE_ADDR 7'h45

`define CLK_HZ 50000000
`define CONV_SHORT_MS 100
`define CONV_LONG_MS 800
`define CONV_SHORT_CYC (`CONV_SHORT_MS * (`CLK_HZ / 1000))
`define CONV_LONG_CYC (`CONV_LONG_MS * (`CLK_HZ / 1000))

`endif

// ===== rtl/light_sensor.v
// light sensor result encoding, limit flags, interrupt and two-wire slave
// Function
// RULE1 - result word: 4-bit exponent, 12-bit mantissa
// RULE2 - value is 1.2 nW times mantissa times 2^exp
// RULE3 - writable upper threshold, same format
// RULE4 - writable lower threshold, same format
// RULE5 - twelve doubling full-scale ranges, codes 0-11
// RULE6 - conversion time 100 ms or 800 ms
// RULE7 - mode 0 shutdown, 1 single, 2 continuous
// RULE8 - overflow flag when range is exceeded
// RULE9 - high flag when result above upper
// RULE10 - low flag when result below lower
// RULE11 - latched interrupt held until host clears
// RULE12 - interrupt polarity: 0 low, 1 high
// RULE13 - host sets active-low before relying on it
// RULE14 - exponent mask reports mantissa only
// RULE15 - 16-bit configuration word, read and write
// RULE16 - fixed 16-bit maker code on read
// RULE17 - unlatched interrupt follows current comparison
// RULE18 - single-shot converts once then shuts down
// RULE19 - all words moved as 16-bit values
`timescale 1ns/100ps
`default_nettype none
`include "light_sensor_regs.vh"

module light_sensor #(
	parameter [6:0] SLAVE_ADDR = `SLAVE_ADDR,
	// value is arbitrary
	parameter [15:0] MAKER_CODE = 16'h0a5c,
	parameter LIGHT_W = 24,
	parameter [31:0] CONV_SHORT_CYCLES = `CONV_SHORT_CYC,
	parameter [31:0] CONV_LONG_CYCLES = `CONV_LONG_CYC
) (
	input wire CLK_I,
	input wire RST_B_I,
	input wire [LIGHT_W-1:0] LIGHT_I,
	input wire SCL_I,
	input wire SDA_I,
	output reg SDA_O,
	output reg SDA_OE_O,
	output reg INT_O
);

	localparam S_IDLE = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_PTR = 3'h2;
	localparam S_WDAT = 3'h3;
	localparam S_RDAT = 3'h4;

	// RULE2 linear value, 1.2 nW steps
	function [26:0] lin;
		input [15:0] w;
		begin
			lin = {15'h0000, w[11:0]} << w[15:12];
		end
	endfunction

	reg rst_meta;
	reg rst_n;
	reg scl_q;
	reg sda_q;
	reg [2:0] state;
	reg [3:0] bitcnt;
	reg ack_phase;
	reg byte_idx;
	reg [7:0] sh;
	reg [7:0] hi_byte;
	reg [7:0] ptr;
	reg [15:0] tx;
	reg [15:0] light_result;
	reg [15:0] upper_threshold;
	reg [15:0] lower_threshold;
	reg [15:0] config_word;
	reg [31:0] timer;
	reg ovf_f;
	reg ready_f;
	reg high_f;
	reg low_f;

	wire scl_rise = scl_i_rise(scl_q, SCL_I);
	wire scl_fall = scl_q & ~SCL_I;
	wire start_c = SCL_I & scl_q & sda_q & ~SDA_I;
	wire stop_c = SCL_I & scl_q & ~sda_q & SDA_I;
	wire [1:0] mode = config_word[`CFG_MODE_HI:`CFG_MODE_LO];
	wire latch_en = config_word[`CFG_LATCH];
	wire [3:0] range_req = config_word[`CFG_RANGE_HI:`CFG_RANGE_LO];

	function scl_i_rise;
		input prev;
		input cur;
		begin
			scl_i_rise = ~prev & cur;
		end
	endfunction

	// RULE16 register read mux
	function [15:0] rd_word;
		input [7:0] p;
		input [15:0] res;
		input [15:0] cfg;
		input [15:0] up;
		input [15:0] lo;
		begin
			case (p)
				`PTR_RESULT: rd_word = res;
				`PTR_CONFIG: rd_word = cfg;
				`PTR_UPPER: rd_word = up;
				`PTR_LOWER: rd_word = lo;
				`PTR_MAKER: rd_word = MAKER_CODE;
				default: rd_word = 16'h0000;
			endcase
		end
	endfunction

	// RULE5 codes above eleven act as the widest range
	wire [3:0] range = (range_req > `RANGE_MAX) ? `RANGE_MAX : range_req;
	wire [LIGHT_W-1:0] shifted = LIGHT_I >> range;
	// RULE8 counts that do not fit twelve bits overflow the range
	wire overflow = |shifted[LIGHT_W-1:12];
	wire [11:0] mant = overflow ? 12'hfff : shifted[11:0];
	// RULE1 exponent equals the selected range
	wire [15:0] full_word = {range, mant};
	wire [26:0] res_lin = lin(full_word);
	// RULE9 strict greater than
	wire cmp_high = res_lin > lin(upper_threshold);
	// RULE10 strict less than
	wire cmp_low = res_lin < lin(lower_threshold);
	// RULE6 conversion length
	wire [31:0] conv_len = config_word[`CFG_LONG] ? CONV_LONG_CYCLES : CONV_SHORT_CYCLES;
	wire conv_done = (mode != `MODE_SHUTDOWN) && (timer >= conv_len - 32'h1);

	wire rx_state = (state == S_ADDR) || (state == S_PTR) || (state == S_WDAT);
	wire cfg_write = scl_fall && ack_phase && (state == S_WDAT) && byte_idx
		&& (ptr == `PTR_CONFIG);
	// ready flag, and latched high and low flags, clear when the configuration word is loaded for a read
	wire cfg_read = scl_fall && ack_phase && (state == S_ADDR) && sh[0]
		&& (ptr == `PTR_CONFIG);

	wire [15:0] cfg_view = {config_word[15:9], ovf_f, ready_f, high_f, low_f,
		config_word[4:0]};
	wire [15:0] rd_now = rd_word(ptr, light_result, cfg_view, upper_threshold, lower_threshold);

	always @(posedge CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// two-wire slave: byte engine with pointer and 16-bit data words
	always @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			state <= S_IDLE;
			bitcnt <= 4'h0;
			ack_phase <= 1'b0;
			byte_idx <= 1'b0;
			sh <= 8'h00;
			hi_byte <= 8'h00;
			ptr <= `PTR_RESULT;
			tx <= 16'h0000;
			SDA_O <= 1'b0;
			SDA_OE_O <= 1'b0;
		end
		else
		begin
			scl_q <= SCL_I;
			sda_q <= SDA_I;
			SDA_O <= 1'b0;
			if (start_c)
			begin
				state <= S_ADDR;
				bitcnt <= 4'h0;
				ack_phase <= 1'b0;
				SDA_OE_O <= 1'b0;
			end
			else if (stop_c)
			begin
				state <= S_IDLE;
				ack_phase <= 1'b0;
				SDA_OE_O <= 1'b0;
			end
			else if (scl_rise)
			begin
				if (rx_state && !ack_phase)
				begin
					sh <= {sh[6:0], SDA_I};
					bitcnt <= bitcnt + 4'h1;
				end
				else if (state == S_RDAT && !ack_phase)
					bitcnt <= bitcnt + 4'h1;
				else if (state == S_RDAT && SDA_I)
					state <= S_IDLE;
			end
			else if (scl_fall && state != S_IDLE)
			begin
				if (!ack_phase && bitcnt == 4'h8)
				begin
					ack_phase <= 1'b1;
					if (state == S_RDAT)
						SDA_OE_O <= 1'b0;
					else if (state == S_ADDR && sh[7:1] != SLAVE_ADDR)
						state <= S_IDLE;
					else
						SDA_OE_O <= 1'b1;
				end
				else if (!ack_phase && state == S_RDAT)
				begin
					SDA_OE_O <= ~tx[15];
					tx <= {tx[14:0], 1'b0};
				end
				else if (ack_phase)
				begin
					ack_phase <= 1'b0;
					bitcnt <= 4'h0;
					SDA_OE_O <= 1'b0;
					case (state)
						S_ADDR:
						begin
							byte_idx <= 1'b0;
							if (sh[0])
							begin
								// RULE19 read word goes out high byte first
								state <= S_RDAT;
								// bit 15 goes out now, so the shifter starts at bit 14
								tx <= {rd_now[14:0], 1'b0};
								SDA_OE_O <= ~rd_now[15];
							end
							else
								state <= S_PTR;
						end
						S_PTR:
						begin
							ptr <= sh;
							byte_idx <= 1'b0;
							state <= S_WDAT;
						end
						S_WDAT:
						begin
							// RULE19 two bytes make one word, high first
							if (!byte_idx)
								hi_byte <= sh;
							byte_idx <= ~byte_idx;
						end
						S_RDAT:
						begin
							SDA_OE_O <= ~tx[15];
							tx <= {tx[14:0], 1'b0};
						end
						default: state <= S_IDLE;
					endcase
				end
			end
		end
	end

	// register writes, conversions, flags and interrupt
	always @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			light_result <= 16'h0000;
			upper_threshold <= `UPPER_RESET;
			lower_threshold <= `LOWER_RESET;
			config_word <= `CONFIG_RESET;
			timer <= 32'h0;
			ovf_f <= 1'b0;
			ready_f <= 1'b0;
			high_f <= 1'b0;
			low_f <= 1'b0;
			INT_O <= 1'b1;
		end
		else
		begin
			if (scl_fall && ack_phase && state == S_WDAT && byte_idx)
			begin
				// RULE3 upper threshold write
				if (ptr == `PTR_UPPER)
					upper_threshold <= {hi_byte, sh};
				// RULE4 lower threshold write
				if (ptr == `PTR_LOWER)
					lower_threshold <= {hi_byte, sh};
			end
			// a configuration write restarts the conversion in progress
			if (cfg_write || mode == `MODE_SHUTDOWN || conv_done)
				timer <= 32'h0;
			else
				timer <= timer + 32'h1;
			if (cfg_write)
				// RULE15 writable configuration fields
				config_word <= {hi_byte, sh} & `CFG_WR_MASK;
			// RULE18 single-shot falls back to shutdown
			else if (conv_done && mode == `MODE_SINGLE)
				config_word[`CFG_MODE_HI:`CFG_MODE_LO] <= `MODE_SHUTDOWN;
			// RULE7 any mode but shutdown converts
			if (conv_done)
			begin
				// RULE14 masked word carries the mantissa only
				light_result <= config_word[`CFG_EXPMASK] ? {4'h0, mant} : full_word;
				ovf_f <= overflow;
				ready_f <= 1'b1;
				// RULE11 latched flags stay set, a new event wins over the clear
				high_f <= (latch_en & high_f & ~cfg_read) | cmp_high;
				low_f <= (latch_en & low_f & ~cfg_read) | cmp_low;
			end
			else if (cfg_read)
			begin
				ready_f <= 1'b0;
				// RULE17 unlatched flags follow only the comparison
				if (latch_en)
				begin
					high_f <= 1'b0;
					low_f <= 1'b0;
				end
			end
			// RULE12 polarity applied to the interrupt state
			INT_O <= config_word[`CFG_POL] ? (high_f | low_f) : ~(high_f | low_f);
		end
	end

endmodule

`default_nettype wire

// ===== verif/light_sensor_props.sv
// assertions on the light sensor bus and interrupt pins
`timescale 1ns/100ps
`default_nettype none
module light_sensor_props (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_O,
	input wire logic INT_O
);
	logic [3:0] nb;
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RST_B_I);
	// clock rises since the last start, saturating so long reads do not wrap
	always_ff @(posedge CLK_I or negedge RST_B_I)
		if (!RST_B_I)
			nb <= 4'h0;
		else if (SCL_I && $fell(SDA_I))
			nb <= 4'h0;
		else if ($rose(SCL_I) && nb != 4'hf)
			nb <= nb + 4'h1;
	drive_low_only_a: assert property (!SDA_O)
		else $error("sda data not low");
	oe_after_fall_a: assert property ($changed(SDA_OE_O) |->
		!SCL_I && ($past(SCL_I, 2) || $past(SCL_I, 3))) else $error("drive moved off fall");
	oe_steady_high_a: assert property ($rose(SCL_I) |-> $stable(SDA_OE_O) [*4])
		else $error("drive moved while clock high");
	start_no_drive_a: assert property (SCL_I && $fell(SDA_I) |-> !SDA_OE_O)
		else $error("driving at start");
	ack_slot_a: assert property ($rose(SDA_OE_O) |-> nb >= 4'h8)
		else $error("drive before ninth slot");
	ack_holds_a: assert property ($rose(SDA_OE_O) |-> SDA_OE_O [*4])
		else $error("drive too short");
	int_reset_idle_a: assert property ($rose(RST_B_I) |-> INT_O [*3])
		else $error("interrupt active after reset");
	oe_reset_idle_a: assert property ($rose(RST_B_I) |-> !SDA_OE_O [*3])
		else $error("driving after reset");
endmodule
bind light_sensor light_sensor_props light_sensor_props_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
	.SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .INT_O(INT_O));
`default_nettype wire

// ===== verif/light_host.sv
// two-wire host model moving 16-bit words to and from the sensor
`timescale 1ns/100ps
`default_nettype none
module light_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// clock moves first, data one edge later, so data never changes on a clock edge
	task automatic step(input logic c, input logic d);
		@(posedge clk_i);
		scl_o <= c;
		@(posedge clk_i);
		sda_low_o <= !d;
		repeat (2) @(posedge clk_i);
	endtask
	// start when s is low, stop when s is high
	task automatic frame(input logic s);
		step(1'b0, !s);
		step(1'b1, !s);
		step(1'b1, s);
	endtask
	task automatic slot(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			step(1'b0, d[i]);
			step(1'b1, d[i]);
			r[i] = sda_i;
		end
	endtask
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] p,
		input logic [15:0] w, output logic [15:0] q, output logic [3:0] k);
		logic [8:0] r;
		frame(1'b0);
		slot({a, 2'b01}, r);
		k[3] = r[0];
		slot({p, 1'b1}, r);
		k[2] = r[0];
		if (rd)
		begin
			frame(1'b0);
			slot({a, 2'b11}, r);
			w = 16'hffff;
		end
		slot({w[15:8], !rd}, r);
		{q[15:8], k[1]} = r;
		slot({w[7:0], 1'b1}, r);
		{q[7:0], k[0]} = r;
		frame(1'b1);
	endtask
endmodule
`default_nettype wire

// ===== verif/light_sensor_bench.sv
// self-checking bench for the light sensor
`timescale 1ns/100ps
`default_nettype none
module light_sensor_bench;
	// value is arbitrary
	localparam logic [15:0] MK = 16'h3c69;
	localparam int LG = 1000;
	logic clk;
	logic rst_b = 1'b0;
	logic [23:0] light = 24'h123456;
	logic [23:0] v;
	logic [15:0] q;
	logic [3:0] k;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	wire scl;
	wire sda_low;
	wire oe;
	wire int_o;
	// open-drain line with a pull-up
	wire sda = !(sda_low || oe);
	light_sensor #(.MAKER_CODE(MK), .CONV_SHORT_CYCLES(40), .CONV_LONG_CYCLES(LG))
		light_sensor_inst (.CLK_I(clk), .RST_B_I(rst_b), .LIGHT_I(light), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(), .SDA_OE_O(oe), .INT_O(int_o));
	light_host light_host_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e)
		begin
			n_errors++;
			$display("mismatch at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] p, input logic [15:0] w);
		light_host_inst.xfer(7'h45, 1'b0, p, w, q, k);
		check({12'h0, k}, 16'h0);
	endtask
	task automatic rd(input logic [7:0] p, input logic [15:0] e);
		light_host_inst.xfer(7'h45, 1'b1, p, 16'h0, q, k);
		check(q, e);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			n_errors++;
			summarize;
		end
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		light_host_inst.xfer(7'h44, 1'b0, 8'h02, 16'h1234, q, k);
		check({12'h0, k}, 16'h000f);
		rd(8'h02, 16'hbfff);
		rd(8'h7e, MK);
		rd(8'h10, 16'h0000);
		wr(8'h01, 16'hb9ff);
		rd(8'h01, 16'hb81c);
		check({15'h0, int_o}, 16'h0000);
		wr(8'h01, 16'h0000);
		check({15'h0, int_o}, 16'h0001);
		for (int r = 0; r < 12; r++)
		begin
			v = light >> r;
			wr(8'h01, {r[3:0], 12'h200});
			rd(8'h00, {r[3:0], |v[23:12] ? 12'hfff : v[11:0]});
			rd(8'h01, {r[3:0], 3'h0, |v[23:12], 8'h80});
		end
		wr(8'h01, 16'h0a00);
		rd(8'h01, 16'h0a00);
		repeat (LG) @(posedge clk);
		rd(8'h01, 16'h0980);
		wr(8'h01, 16'hb204);
		rd(8'h00, 16'h0246);
		wr(8'h00, 16'h1234);
		rd(8'h00, 16'h0246);
		wr(8'h02, 16'h0040);
		rd(8'h02, 16'h0040);
		wr(8'h03, 16'h0020);
		rd(8'h03, 16'h0020);
		light <= 24'd100;
		wr(8'h01, 16'h0400);
		rd(8'h01, 16'h04c0);
		check({15'h0, int_o}, 16'h0000);
		light <= 24'd50;
		repeat (100) @(posedge clk);
		check({15'h0, int_o}, 16'h0001);
		light <= 24'd10;
		repeat (100) @(posedge clk);
		check({15'h0, int_o}, 16'h0000);
		rd(8'h01, 16'h04a0);
		light <= 24'd100;
		wr(8'h01, 16'h0410);
		repeat (100) @(posedge clk);
		light <= 24'd50;
		repeat (100) @(posedge clk);
		check({15'h0, int_o}, 16'h0000);
		rd(8'h01, 16'h04d0);
		repeat (100) @(posedge clk);
		check({15'h0, int_o}, 16'h0001);
		summarize;
	end
endmodule
`default_nettype wire
